// ---- common/bt_pkg.sv ----
// constants and types for the basic timer, watchdog and stabilisation block
// Contract
// - reset clears timer_control to zero: watchdog on, clock oscillator/4096.
// - watchdog reset disabled only while the top four control bits hold 1010.
// - writing one to control bit 1 clears the counter; zero does nothing.
// - writing one to control bit 0 clears both dividers, unless capture clock external.
// - counter clock is oscillator divided by 4096, 1024 or 128.
// - counter is an 8-bit read-only up-counter stepped per prescaled tick.
// - with watchdog enabled, counter overflow out of bit 7 resets the system; code resets on carry of an accumulator stepped only in run mode.
// - 3-bit period field divides the watchdog time by field value plus one.
// - undivided overflow period is oscillator period times divider times 256.
// - halving bit passes horizontal sync straight when zero, halved when one.
// - stop release counts at /4096 after reset, preset clock after external interrupt.
// - stabilisation ends on counter bit 4 overflow, then cpu clock is enabled.
// - cpu clock stays gated off during the stabilisation interval.
package bt_pkg;
    localparam logic [7:0] TCTL_ADDR   = 8'hd3;
    localparam logic [7:0] WPER_ADDR   = 8'hec;
    localparam logic [7:0] TCNT_ADDR   = 8'hfd;
    localparam logic [7:0] TCTL_RESET  = 8'h00;
    localparam logic [7:0] WPER_RESET  = 8'h00;
    localparam int         SIG_HI      = 7;
    localparam int         SIG_LO      = 4;
    localparam int         SEL_HI      = 3;
    localparam int         SEL_LO      = 2;
    localparam int         CLR_CNT_BIT = 1;
    localparam int         CLR_DIV_BIT = 0;
    localparam int         PER_HI      = 2;
    localparam int         PER_LO      = 0;
    localparam int         HALVE_BIT   = 3;
    localparam logic [3:0] WDOFF_SIG   = 4'ha;
    localparam logic [1:0] SEL_4096    = 2'h0;
    localparam logic [1:0] SEL_1024    = 2'h1;
    localparam logic [1:0] SEL_128     = 2'h2;
    localparam int         DIV_W       = 12;
    localparam logic [11:0] MASK_4096  = 12'hfff;
    localparam logic [11:0] MASK_1024  = 12'h3ff;
    localparam logic [11:0] MASK_128   = 12'h07f;
    localparam logic [4:0] STAB_LOW    = 5'h1f;

    typedef enum logic [1:0] {
        BT_STAB = 2'b00,
        BT_RUN  = 2'b01,
        BT_STOP = 2'b10
    } bt_mode_e;

    typedef struct packed {
        bt_mode_e   mode;
        logic [3:0] sig;
        logic [1:0] sel;
        logic [2:0] per;
        logic       halve;
        logic [7:0] count;
        logic [8:0] acc;
        logic       wdt_reset;
        logic       cpu_clk_en;
        logic       div_clear;
        logic       hs_prev;
        logic       hs_half;
        logic       hsync_out;
        logic [7:0] rdata;
    } bt_core_s;

    typedef struct packed {
        logic [11:0] div;
        logic        tick;
        logic        cap_div_clear;
    } bt_pre_s;
endpackage : bt_pkg

// ---- common/bt_if.sv ----
// link between the timer core and its prescaler
`timescale 1ns/10ps
interface bt_if;
    logic       div_clear;
    logic       osc_run;
    logic [1:0] sel;
    logic       tick;
    logic       cap_div_clear;

    modport core (
        output div_clear,
        output osc_run,
        output sel,
        input  tick,
        input  cap_div_clear
    );
    modport pre (
        input  div_clear,
        input  osc_run,
        input  sel,
        output tick,
        output cap_div_clear
    );
endinterface : bt_if

// ---- verilog/bt_prescaler.sv ----
// oscillator divider and tick selector for the basic timer
`timescale 1ns/10ps
module bt_prescaler (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cap_ext_clk,
    bt_if.pre        pif
);
    bt_pkg::bt_pre_s st;
    bt_pkg::bt_pre_s next_st;

    function automatic logic [11:0] sel_mask(input logic [1:0] sel);
        case (sel)
            bt_pkg::SEL_4096: sel_mask = bt_pkg::MASK_4096;
            bt_pkg::SEL_1024: sel_mask = bt_pkg::MASK_1024;
            default:          sel_mask = bt_pkg::MASK_128;
        endcase
    endfunction : sel_mask

    always_comb begin
        next_st = st;
        next_st.tick = pif.osc_run && !pif.div_clear &&
                       ((st.div & sel_mask(pif.sel)) == sel_mask(pif.sel));
        next_st.cap_div_clear = pif.div_clear && !cap_ext_clk;
        if (pif.div_clear) begin
            next_st.div = '0;
        end else if (pif.osc_run) begin
            next_st.div = st.div + 12'h001;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pif.tick          = st.tick;
    assign pif.cap_div_clear = st.cap_div_clear;
endmodule : bt_prescaler

// ---- verilog/bt_watchdog.sv ----
// basic timer with watchdog, period scaling, sync halving and start-up hold
`timescale 1ns/10ps
module bt_watchdog (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       stop_req,
    input  wire logic       ext_wake,
    input  wire logic       cap_ext_clk,
    output logic            cap_div_clear,
    input  wire logic       hsync_in,
    output logic            hsync_out,
    output logic            wdt_reset,
    output logic            cpu_clk_en
);
    bt_pkg::bt_core_s st;
    bt_pkg::bt_core_s next_st;
    bt_if             pif ();

    logic wr_tctl;
    logic wr_wper;
    logic clr_cnt;
    logic wd_enabled;
    logic [8:0] acc_sum;

    bt_prescaler u_pre (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .cap_ext_clk (cap_ext_clk),
        .pif         (pif)
    );

    assign wr_tctl    = reg_wr && (reg_addr == bt_pkg::TCTL_ADDR);
    assign wr_wper    = reg_wr && (reg_addr == bt_pkg::WPER_ADDR);
    assign clr_cnt    = wr_tctl && reg_wdata[bt_pkg::CLR_CNT_BIT];
    // only the signature switches the watchdog off
    assign wd_enabled = (st.sig != bt_pkg::WDOFF_SIG);
    // each run-mode tick adds per+1, carry out marks the shortened period
    assign acc_sum    = {1'b0, st.acc[7:0]} + {5'h00, 1'b0, st.per} + 9'h001;

    always_comb begin
        next_st           = st;
        next_st.wdt_reset = 1'b0;
        next_st.div_clear = 1'b0;

        if (wr_tctl) begin
            next_st.sig = reg_wdata[bt_pkg::SIG_HI:bt_pkg::SIG_LO];
            next_st.sel = reg_wdata[bt_pkg::SEL_HI:bt_pkg::SEL_LO];
            next_st.div_clear = reg_wdata[bt_pkg::CLR_DIV_BIT];
        end
        if (wr_wper) begin
            next_st.per   = reg_wdata[bt_pkg::PER_HI:bt_pkg::PER_LO];
            next_st.halve = reg_wdata[bt_pkg::HALVE_BIT];
        end

        case (st.mode)
            bt_pkg::BT_STAB: begin
                if (pif.tick && (st.count[4:0] == bt_pkg::STAB_LOW)) begin
                    next_st.mode = bt_pkg::BT_RUN;
                end
            end
            bt_pkg::BT_RUN: begin
                if (stop_req) begin
                    next_st.mode = bt_pkg::BT_STOP;
                end
            end
            bt_pkg::BT_STOP: begin
                // external wake keeps the preset clock select
                if (ext_wake) begin
                    next_st.mode = bt_pkg::BT_STAB;
                end
            end
            default: begin
                next_st.mode = bt_pkg::BT_STAB;
            end
        endcase

        // counter clear on write of one
        if (clr_cnt || (st.mode == bt_pkg::BT_STOP && ext_wake)) begin
            next_st.count = 8'h00;
            next_st.acc   = 9'h000;
        end else if (pif.tick && st.mode != bt_pkg::BT_STOP) begin
            next_st.count = st.count + 8'h01;
            if (st.mode == bt_pkg::BT_RUN) begin
                // with per zero the carry is the 256-tick overflow
                next_st.acc = {1'b0, acc_sum[7:0]};
                // overflow resets the system while enabled
                next_st.wdt_reset = acc_sum[8] && wd_enabled;
            end
        end

        // cpu clock gated until run mode
        next_st.cpu_clk_en = (next_st.mode == bt_pkg::BT_RUN);

        next_st.hs_prev = hsync_in;
        if (hsync_in && !st.hs_prev) begin
            next_st.hs_half = !st.hs_half;
        end
        next_st.hsync_out = st.halve ? next_st.hs_half : hsync_in;

        case (reg_addr)
            bt_pkg::TCTL_ADDR: next_st.rdata = {st.sig, st.sel, 2'b00};
            bt_pkg::WPER_ADDR: next_st.rdata = {4'h0, st.halve, st.per};
            bt_pkg::TCNT_ADDR: next_st.rdata = st.count;
            default:           next_st.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st      <= '0;
            st.sig  <= bt_pkg::TCTL_RESET[bt_pkg::SIG_HI:bt_pkg::SIG_LO];
            st.sel  <= bt_pkg::TCTL_RESET[bt_pkg::SEL_HI:bt_pkg::SEL_LO];
            st.per  <= bt_pkg::WPER_RESET[bt_pkg::PER_HI:bt_pkg::PER_LO];
            st.mode <= bt_pkg::BT_STAB;
        end else begin
            st <= next_st;
        end
    end

    assign pif.div_clear = st.div_clear;
    assign pif.osc_run   = (st.mode != bt_pkg::BT_STOP);
    assign pif.sel       = st.sel;
    assign cap_div_clear = pif.cap_div_clear;
    assign reg_rdata     = st.rdata;
    assign hsync_out     = st.hsync_out;
    assign wdt_reset     = st.wdt_reset;
    assign cpu_clk_en    = st.cpu_clk_en;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_wd_off;
        (st.sig == bt_pkg::WDOFF_SIG) && !wr_tctl |=> !wdt_reset;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog fired while disabled");

    property p_cnt_clr;
        clr_cnt |=> (st.count == 8'h00);
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared");

    property p_cnt_step;
        pif.tick && !clr_cnt && st.mode == bt_pkg::BT_RUN |=> st.count == $past(st.count) + 8'h01;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

    property p_cnt_hold;
        !pif.tick && !clr_cnt && !ext_wake |=> st.count == $past(st.count);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without tick");

    property p_wd_fire;
        st.mode == bt_pkg::BT_RUN && wd_enabled && !wr_tctl && pif.tick &&
        st.per == 3'h0 && st.count == 8'hff && st.acc == 9'h0ff |=> wdt_reset;
    endproperty
    a_wd_fire: assert property (p_wd_fire) else $error("overflow without reset");

    property p_acc_add;
        st.mode == bt_pkg::BT_RUN && pif.tick && !clr_cnt && !stop_req
        |=> st.acc[7:0] == 8'($past(st.acc) + {6'h00, $past(st.per)} + 9'h001);
    endproperty
    a_acc_add: assert property (p_acc_add) else $error("period scaling wrong");

    property p_pulse;
        wdt_reset |=> !wdt_reset;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset request longer than one cycle");

    property p_stab_end;
        st.mode == bt_pkg::BT_STAB && pif.tick && st.count[4:0] == bt_pkg::STAB_LOW
        |=> st.mode == bt_pkg::BT_RUN && cpu_clk_en;
    endproperty
    a_stab_end: assert property (p_stab_end) else $error("stabilisation did not end");

    property p_cpu_idle;
        st.mode != bt_pkg::BT_RUN |-> !cpu_clk_en;
    endproperty
    a_cpu_idle: assert property (p_cpu_idle) else $error("cpu clock on during hold");

    property p_wake;
        st.mode == bt_pkg::BT_STOP && ext_wake |=> st.mode == bt_pkg::BT_STAB && st.count == 8'h00;
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not restart hold");

    property p_hs_plain;
        !st.halve |=> hsync_out == $past(hsync_in);
    endproperty
    a_hs_plain: assert property (p_hs_plain) else $error("sync not passed straight");

    property p_clr_div;
        wr_tctl && reg_wdata[bt_pkg::CLR_DIV_BIT] |=> pif.div_clear;
    endproperty
    a_clr_div: assert property (p_clr_div) else $error("divider clear strobe missing");

    property p_cap_clear;
        pif.div_clear && !cap_ext_clk |=> cap_div_clear;
    endproperty
    a_cap_clear: assert property (p_cap_clear) else $error("capture divider not cleared");

    property p_cap_keep;
        !pif.div_clear || cap_ext_clk |=> !cap_div_clear;
    endproperty
    a_cap_keep: assert property (p_cap_keep) else $error("capture divider cleared wrongly");

    property p_div_no_tick;
        pif.div_clear |=> !pif.tick;
    endproperty
    a_div_no_tick: assert property (p_div_no_tick) else $error("tick during divider clear");

    property p_sig_wr;
        wr_tctl |=> st.sig == $past(reg_wdata[bt_pkg::SIG_HI:bt_pkg::SIG_LO]);
    endproperty
    a_sig_wr: assert property (p_sig_wr) else $error("signature field not written");

    property p_sel_wr;
        wr_tctl |=> st.sel == $past(reg_wdata[bt_pkg::SEL_HI:bt_pkg::SEL_LO]);
    endproperty
    a_sel_wr: assert property (p_sel_wr) else $error("clock select not written");

    property p_per_wr;
        wr_wper |=> st.per == $past(reg_wdata[bt_pkg::PER_HI:bt_pkg::PER_LO]) &&
                    st.halve == $past(reg_wdata[bt_pkg::HALVE_BIT]);
    endproperty
    a_per_wr: assert property (p_per_wr) else $error("period register not written");

    property p_cnt_ro;
        reg_wr && reg_addr == bt_pkg::TCNT_ADDR && !pif.tick && !ext_wake |=> st.count == $past(st.count);
    endproperty
    a_cnt_ro: assert property (p_cnt_ro) else $error("count written by software");

    property p_rd_cnt;
        reg_addr == bt_pkg::TCNT_ADDR |=> reg_rdata == $past(st.count);
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("count read wrong");

    property p_rd_ctl;
        reg_addr == bt_pkg::TCTL_ADDR |=> reg_rdata[1:0] == 2'b00 && reg_rdata[7:4] == $past(st.sig);
    endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");

    property p_no_wd_hold;
        st.mode != bt_pkg::BT_RUN |=> !wdt_reset;
    endproperty
    a_no_wd_hold: assert property (p_no_wd_hold) else $error("reset request outside run mode");

    property p_stop_enter;
        st.mode == bt_pkg::BT_RUN && stop_req |=> st.mode == bt_pkg::BT_STOP && !cpu_clk_en;
    endproperty
    a_stop_enter: assert property (p_stop_enter) else $error("stop entry kept cpu clock");

    property p_stop_halt;
        st.mode == bt_pkg::BT_STOP |=> !pif.tick;
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("tick while stopped");

    property p_tick_gap;
        pif.tick |=> !pif.tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks back to back");

    property p_hs_toggle;
        st.halve && hsync_in && !st.hs_prev |=> hsync_out != $past(st.hs_half);
    endproperty
    a_hs_toggle: assert property (p_hs_toggle) else $error("halved sync did not toggle");

    property p_hs_keep;
        st.halve && !(hsync_in && !st.hs_prev) |=> hsync_out == $past(st.hs_half);
    endproperty
    a_hs_keep: assert property (p_hs_keep) else $error("halved sync moved without edge");

    property p_cov_stab;
        st.mode == bt_pkg::BT_STAB ##1 st.mode == bt_pkg::BT_RUN;
    endproperty
    c_cov_stab: cover property (p_cov_stab);

    property p_cov_fire;
        wdt_reset;
    endproperty
    c_cov_fire: cover property (p_cov_fire);

    property p_cov_wake;
        st.mode == bt_pkg::BT_STOP ##1 st.mode == bt_pkg::BT_STAB;
    endproperty
    c_cov_wake: cover property (p_cov_wake);

    property p_cov_halve;
        st.halve && hsync_out;
    endproperty
    c_cov_halve: cover property (p_cov_halve);

    property p_cov_capclr;
        cap_div_clear;
    endproperty
    c_cov_capclr: cover property (p_cov_capclr);
endmodule : bt_watchdog

// ---- testbench/tb.sv ----
// self-checking bench for the basic timer, watchdog and start-up hold
`timescale 1ns/10ps
module tb;
    logic       core_clk, reset_n, reg_wr, stop_req, ext_wake, cap_ext_clk, hsync_in;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic       cap_div_clear, hsync_out, wdt_reset, cpu_clk_en, hs_prev, wide;
    int         num_errors, samples_checked, wdt_cnt, cdc_cnt, hs_rise, n, k;

    bt_watchdog i_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .stop_req(stop_req), .ext_wake(ext_wake),
        .cap_ext_clk(cap_ext_clk), .cap_div_clear(cap_div_clear), .hsync_in(hsync_in),
        .hsync_out(hsync_out), .wdt_reset(wdt_reset), .cpu_clk_en(cpu_clk_en));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // pulse counters and edge detect on the outputs
    always @(posedge core_clk) begin
        hs_prev <= hsync_out;
        wide    <= wdt_reset;
        if (hsync_out === 1'b1 && hs_prev === 1'b0) hs_rise <= hs_rise + 1;
        if (wdt_reset === 1'b1) wdt_cnt <= wdt_cnt + 1;
        if (cap_div_clear === 1'b1) cdc_cnt <= cdc_cnt + 1;
        if (wdt_reset === 1'b1) chk({7'h00, wide}, 8'h00);
    end

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rdr(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        repeat (2) @(posedge core_clk);
        #1 rd = reg_rdata;
    endtask : rdr

    task wait_cpu(input logic lvl, input int lim);
        n = 0;
        #1;
        while (cpu_clk_en !== lvl && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : wait_cpu

    task finish_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        finish_test();
    end

    initial begin
        {reset_n, reg_wr, stop_req, ext_wake, cap_ext_clk, hsync_in, hs_prev, wide} = 8'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        {num_errors, samples_checked, wdt_cnt, cdc_cnt, hs_rise} = '0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        rdr(bt_pkg::TCTL_ADDR); chk(rd, 8'h00);
        rdr(bt_pkg::WPER_ADDR); chk(rd, 8'h00);
        // first tick after reset comes at the slowest rate
        repeat (4150) @(posedge core_clk);
        rdr(bt_pkg::TCNT_ADDR); chk(rd, 8'h01);
        chk({7'h00, cpu_clk_en}, 8'h00);
        wr(bt_pkg::TCTL_ADDR, 8'ha8);
        wait_cpu(1'b1, 5000);
        rdr(bt_pkg::TCNT_ADDR); chk(rd, 8'h20);
        // clear, then a write to the count must not land
        wr(bt_pkg::TCTL_ADDR, 8'hab);
        wr(bt_pkg::TCNT_ADDR, 8'hff);
        rdr(bt_pkg::TCNT_ADDR); chk(rd, 8'h00);
        repeat (1330) @(posedge core_clk);
        rdr(bt_pkg::TCNT_ADDR); chk(rd, 8'h0a);
        wr(bt_pkg::TCTL_ADDR, 8'ha7);
        repeat (4600) @(posedge core_clk);
        rdr(bt_pkg::TCNT_ADDR); chk(rd, 8'h04);
        for (int e = 0; e < 2; e++) begin
            cap_ext_clk <= e[0];
            k = cdc_cnt;
            wr(bt_pkg::TCTL_ADDR, 8'ha9);
            repeat (4) @(posedge core_clk);
            chk(8'(cdc_cnt - k), e ? 8'h00 : 8'h01);
        end
        cap_ext_clk <= 1'b0;
        // watchdog at a quarter of the overflow period
        wr(bt_pkg::WPER_ADDR, 8'h03);
        k = wdt_cnt;
        wr(bt_pkg::TCTL_ADDR, 8'h0b);
        n = 0;
        while (wdt_cnt == k && n < 9000) begin
            @(posedge core_clk);
            n++;
        end
        chk(8'(n >= 8100 && n <= 8300), 8'h01);
        repeat (3) @(posedge core_clk);
        chk(8'(wdt_cnt - k), 8'h01);
        wr(bt_pkg::TCTL_ADDR, 8'hab);
        wr(bt_pkg::WPER_ADDR, 8'h07);
        rdr(bt_pkg::TCTL_ADDR); chk(rd, 8'ha8);
        rdr(bt_pkg::WPER_ADDR); chk(rd, 8'h07);
        k = wdt_cnt;
        repeat (5000) @(posedge core_clk);
        chk(8'(wdt_cnt - k), 8'h00);
        // near-miss signatures keep the watchdog armed
        for (int s = 0; s < 2; s++) begin
            k = wdt_cnt;
            wr(bt_pkg::TCTL_ADDR, s ? 8'hbb : 8'h2b);
            repeat (4300) @(posedge core_clk);
            chk(8'(wdt_cnt - k), 8'h01);
        end
        // software clears the armed counter well inside the eighth period
        k = wdt_cnt;
        repeat (3) begin
            wr(bt_pkg::TCTL_ADDR, 8'h0b);
            repeat (3000) @(posedge core_clk);
        end
        chk(8'(wdt_cnt - k), 8'h00);
        // undivided period: 256 ticks at /128
        wr(bt_pkg::WPER_ADDR, 8'h00);
        k = wdt_cnt;
        wr(bt_pkg::TCTL_ADDR, 8'h0b);
        repeat (32700) @(posedge core_clk);
        chk(8'(wdt_cnt - k), 8'h00);
        repeat (200) @(posedge core_clk);
        chk(8'(wdt_cnt - k), 8'h01);
        wr(bt_pkg::TCTL_ADDR, 8'hab);
        for (int h = 0; h < 2; h++) begin
            wr(bt_pkg::WPER_ADDR, {4'h0, h[0], 3'h7});
            k = hs_rise;
            repeat (8) begin
                hsync_in <= 1'b1;
                repeat (4) @(posedge core_clk);
                hsync_in <= 1'b0;
                repeat (4) @(posedge core_clk);
            end
            repeat (4) @(posedge core_clk);
            chk(8'(hs_rise - k), h ? 8'h04 : 8'h08);
        end
        // stop, then wake by external interrupt at the preset rate
        stop_req <= 1'b1;
        @(posedge core_clk);
        stop_req <= 1'b0;
        wait_cpu(1'b0, 5);
        chk({7'h00, cpu_clk_en}, 8'h00);
        repeat (20) @(posedge core_clk);
        ext_wake <= 1'b1;
        @(posedge core_clk);
        ext_wake <= 1'b0;
        wait_cpu(1'b1, 5000);
        chk(8'(n >= 3900 && n <= 4300), 8'h01);
        finish_test();
    end
endmodule : tb
